// File: verilog/servo_monitor_map_regs.vh
// register map, reset values and answer codes of the monitor/command bank
`ifndef SERVO_MONITOR_MAP_REGS_VH
`define SERVO_MONITOR_MAP_REGS_VH

// 32-bit monitoring values and gear settings, low word at the even address
`define ADDR_COMMAND_PULSE_COUNT   16'h0434
`define ADDR_FEEDBACK_PULSE_COUNT  16'h0436
`define ADDR_FOLLOWING_ERROR_COUNT 16'h0438
`define ADDR_CUMULATIVE_LOAD       16'h043a
`define ADDR_INERTIA_RATIO         16'h043c
`define ADDR_ENCODER_ANGLE         16'h043e
`define ADDR_ENCODER_TURN_COUNT    16'h0440
`define ADDR_GEAR_NUMERATOR        16'h0460
`define ADDR_GEAR_DENOMINATOR      16'h0462
`define ADDR_ACTUAL_POSITION_LOW   16'h05f2

// 16-bit registers
`define ADDR_ACTIVE_ALARM          16'h044a
`define ADDR_LINK_IO_SIGNALS       16'h0451
`define ADDR_LINK_OUTPUT_INVERT    16'h0452
`define ADDR_OPERATING_STATE       16'h0457
`define ADDR_FIRMWARE_VERSION      16'h045e
`define ADDR_LOGIC_VERSION         16'h045f
`define ADDR_HISTORY_ALARM_CLEAR   16'h0520
`define ADDR_ACTIVE_ALARM_CLEAR    16'h0521
`define ADDR_ENCODER_ALARM_CLEAR   16'h0522
`define ADDR_ENCODER_TURNS_CLEAR   16'h0523
`define ADDR_JOG_SPEED_CONTROL     16'h0528
`define ADDR_JOG_POSITION_CONTROL  16'h0529
`define ADDR_FACTORY_DEFAULT       16'h0540
`define ADDR_DRIVE_RESET           16'h0541
`define ADDR_RUNNING_GROUP_NUMBER  16'h05f0
`define ADDR_RUNNING_GROUP_INDEX   16'h05f1

// field positions in the jog registers
`define JOG_ENABLE_BIT             15
`define JOG_FORWARD_BIT            1
`define JOG_REVERSE_BIT            0

// value that triggers an action register
`define ACTION_TRIGGER             16'h0001

// reset / factory-default values of the volatile settings
`define LINK_IO_RESET              16'h0000
`define LINK_INVERT_RESET          16'h0000
`define GEAR_NUMERATOR_RESET       32'h00000001
`define GEAR_DENOMINATOR_RESET     32'h00000001
`define JOG_CONTROL_RESET          16'h0000

// exception codes
`define EXC_NONE                   8'h00
`define EXC_BAD_ADDRESS            8'h02

`endif

// File: verilog/servo_monitor_core.v
// monitor and command register bank of the servo drive, word access port
`timescale 1ns/1ns
// What this block does
// - read-only 32-bit command pulse count
// - read-only feedback and following error counts
// - read-only encoder single-turn angle
// - read-only encoder multi-turn revolution count
// - volatile io, invert, gear settings take effect
// - write 1 clears alarm history
// - write 1 clears the pending alarm
// - write 1 clears encoder alarm
// - write 1 zeroes encoder turn count
// - jog speed bits: enable, forward, reverse
// - jog position bits: point mode, direction
// - write 1 restores factory defaults
// - read-only running data group numbers
// - actual position low half readable
// - actual position high half follows low
// - unknown address answers exception code 02
`include "servo_monitor_map_regs.vh"

module servo_monitor_command_regs #(
  parameter [15:0] FIRMWARE_VERSION = 16'h0001, // arbitrary value
  parameter [15:0] LOGIC_VERSION    = 16'h0001  // arbitrary value
) (
  // clock, reset, enable
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  // word request from the link frame decoder
  input  wire        req_valid,
  input  wire        req_write,
  input  wire [15:0] req_addr,
  input  wire [15:0] req_wdata,
  // answer
  output reg         rsp_valid,
  output reg  [15:0] rsp_rdata,
  output reg         rsp_error,
  output reg  [7:0]  rsp_code,
  // monitored drive state
  input  wire [31:0] command_pulse_count,
  input  wire [31:0] feedback_pulse_count,
  input  wire [31:0] following_error_count,
  input  wire [31:0] cumulative_load,
  input  wire [31:0] inertia_ratio,
  input  wire [31:0] encoder_angle,
  input  wire [31:0] encoder_turn_count,
  input  wire [15:0] active_alarm,
  input  wire [15:0] operating_state,
  input  wire [15:0] running_group_number,
  input  wire [15:0] running_group_index,
  input  wire [31:0] actual_position,
  // volatile settings
  output reg  [15:0] link_io_signals,
  output reg  [15:0] link_output_invert,
  output reg  [31:0] gear_numerator,
  output reg  [31:0] gear_denominator,
  // jog controls
  output wire        jog_servo_enable,
  output wire        jog_forward,
  output wire        jog_reverse,
  output wire        point_mode_enable,
  output wire        point_forward,
  output wire        point_reverse,
  // one-cycle action pulses
  output reg         history_alarm_clear_pulse,
  output reg         active_alarm_clear_pulse,
  output reg         encoder_alarm_clear_pulse,
  output reg         encoder_turns_clear_pulse,
  output reg         factory_default_pulse,
  output reg         drive_reset_pulse
);

  // ==========================================================
  // reset release
  reg        rst_meta_n;
  reg        rst_sync_n;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ==========================================================
  // address decode
  reg [15:0] jog_speed_control;
  reg [15:0] jog_position_control;
  reg [15:0] gear_stage;
  reg [15:0] snap_high;
  reg [15:0] snap_base;
  reg        snap_valid;

  wire [15:0] base = {req_addr[15:1], 1'b0};
  wire        take = ce & req_valid;

  reg         is_wide;
  reg  [31:0] wide_value;
  reg         hit;
  reg  [15:0] narrow_value;

  always @* begin
    is_wide    = 1'b1;
    wide_value = 32'h00000000;
    case (base)
      `ADDR_COMMAND_PULSE_COUNT:   wide_value = command_pulse_count;
      `ADDR_FEEDBACK_PULSE_COUNT:  wide_value = feedback_pulse_count;
      `ADDR_FOLLOWING_ERROR_COUNT: wide_value = following_error_count;
      `ADDR_CUMULATIVE_LOAD:       wide_value = cumulative_load;
      `ADDR_INERTIA_RATIO:         wide_value = inertia_ratio;
      `ADDR_ENCODER_ANGLE:         wide_value = encoder_angle;
      `ADDR_ENCODER_TURN_COUNT:    wide_value = encoder_turn_count;
      `ADDR_GEAR_NUMERATOR:        wide_value = gear_numerator;
      `ADDR_GEAR_DENOMINATOR:      wide_value = gear_denominator;
      `ADDR_ACTUAL_POSITION_LOW:   wide_value = actual_position;
      default:                     is_wide = 1'b0;
    endcase
  end

  always @* begin
    hit          = 1'b1;
    narrow_value = 16'h0000;
    case (req_addr)
      `ADDR_ACTIVE_ALARM:         narrow_value = active_alarm;
      `ADDR_LINK_IO_SIGNALS:      narrow_value = link_io_signals;
      `ADDR_LINK_OUTPUT_INVERT:   narrow_value = link_output_invert;
      `ADDR_OPERATING_STATE:      narrow_value = operating_state;
      `ADDR_FIRMWARE_VERSION:     narrow_value = FIRMWARE_VERSION;
      `ADDR_LOGIC_VERSION:        narrow_value = LOGIC_VERSION;
      `ADDR_HISTORY_ALARM_CLEAR:  narrow_value = 16'h0000;
      `ADDR_ACTIVE_ALARM_CLEAR:   narrow_value = 16'h0000;
      `ADDR_ENCODER_ALARM_CLEAR:  narrow_value = 16'h0000;
      `ADDR_ENCODER_TURNS_CLEAR:  narrow_value = 16'h0000;
      `ADDR_JOG_SPEED_CONTROL:    narrow_value = jog_speed_control;
      `ADDR_JOG_POSITION_CONTROL: narrow_value = jog_position_control;
      `ADDR_FACTORY_DEFAULT:      narrow_value = 16'h0000;
      `ADDR_DRIVE_RESET:          narrow_value = 16'h0000;
      `ADDR_RUNNING_GROUP_NUMBER: narrow_value = running_group_number;
      `ADDR_RUNNING_GROUP_INDEX:  narrow_value = running_group_index;
      default:                    hit = 1'b0;
    endcase
  end

  wire mapped = is_wide | hit;

  // high word comes from the snapshot taken with its low word, so a
  // counter carrying between the two reads cannot tear the value
  wire        snap_match = snap_valid & (snap_base == base);
  wire [15:0] high_word  = snap_match ? snap_high : wide_value[31:16];
  wire [15:0] read_word  = !is_wide    ? narrow_value :
                           req_addr[0] ? high_word : wide_value[15:0];

  // ==========================================================
  // answer path
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rsp_valid  <= 1'b0;
      rsp_rdata  <= 16'h0000;
      rsp_error  <= 1'b0;
      rsp_code   <= `EXC_NONE;
      snap_high  <= 16'h0000;
      snap_base  <= 16'h0000;
      snap_valid <= 1'b0;
    end else if (ce) begin
      rsp_valid <= req_valid;
      if (req_valid) begin
        rsp_error <= ~mapped;
        rsp_code  <= mapped ? `EXC_NONE : `EXC_BAD_ADDRESS;
        rsp_rdata <= (mapped && !req_write) ? read_word : 16'h0000;
        if (!req_write && is_wide && !req_addr[0]) begin
          snap_high  <= wide_value[31:16];
          snap_base  <= base;
          snap_valid <= 1'b1;
        end else if (!req_write && is_wide && req_addr[0]) begin
          snap_valid <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // volatile settings, lost at power off as nothing backs them up
  wire wr       = take & req_write;
  wire restore  = wr && (req_addr == `ADDR_FACTORY_DEFAULT) &&
                  (req_wdata == `ACTION_TRIGGER);

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      link_io_signals      <= `LINK_IO_RESET;
      link_output_invert   <= `LINK_INVERT_RESET;
      gear_numerator       <= `GEAR_NUMERATOR_RESET;
      gear_denominator     <= `GEAR_DENOMINATOR_RESET;
      jog_speed_control    <= `JOG_CONTROL_RESET;
      jog_position_control <= `JOG_CONTROL_RESET;
      gear_stage           <= 16'h0000;
    end else if (restore) begin
      link_io_signals      <= `LINK_IO_RESET;
      link_output_invert   <= `LINK_INVERT_RESET;
      gear_numerator       <= `GEAR_NUMERATOR_RESET;
      gear_denominator     <= `GEAR_DENOMINATOR_RESET;
      jog_speed_control    <= `JOG_CONTROL_RESET;
      jog_position_control <= `JOG_CONTROL_RESET;
    end else if (wr) begin
      case (req_addr)
        `ADDR_LINK_IO_SIGNALS:      link_io_signals <= req_wdata;
        `ADDR_LINK_OUTPUT_INVERT:   link_output_invert <= req_wdata;
        `ADDR_GEAR_NUMERATOR:       gear_stage <= req_wdata;
        `ADDR_GEAR_DENOMINATOR:     gear_stage <= req_wdata;
        // the high word commits both halves at once
        `ADDR_GEAR_NUMERATOR + 16'h0001:
          gear_numerator <= {req_wdata, gear_stage};
        `ADDR_GEAR_DENOMINATOR + 16'h0001:
          gear_denominator <= {req_wdata, gear_stage};
        `ADDR_JOG_SPEED_CONTROL:    jog_speed_control <= req_wdata;
        `ADDR_JOG_POSITION_CONTROL: jog_position_control <= req_wdata;
        default:                    gear_stage <= gear_stage;
      endcase
    end
  end

  assign jog_servo_enable  = jog_speed_control[`JOG_ENABLE_BIT];
  assign jog_forward       = jog_speed_control[`JOG_FORWARD_BIT];
  assign jog_reverse       = jog_speed_control[`JOG_REVERSE_BIT];
  assign point_mode_enable = jog_position_control[`JOG_ENABLE_BIT];
  assign point_forward     = jog_position_control[`JOG_FORWARD_BIT];
  assign point_reverse     = jog_position_control[`JOG_REVERSE_BIT];

  // ==========================================================
  // action registers: one pulse per write of exactly 1
  localparam integer ACTIONS = 6;

  wire [16*ACTIONS-1:0] action_addr = {`ADDR_DRIVE_RESET,
                                       `ADDR_FACTORY_DEFAULT,
                                       `ADDR_ENCODER_TURNS_CLEAR,
                                       `ADDR_ENCODER_ALARM_CLEAR,
                                       `ADDR_ACTIVE_ALARM_CLEAR,
                                       `ADDR_HISTORY_ALARM_CLEAR};
  wire [ACTIONS-1:0]    fire;

  genvar i;
  generate
    for (i = 0; i < ACTIONS; i = i + 1) begin : g_action
      assign fire[i] = wr && (req_addr == action_addr[16*i+15:16*i]) &&
                       (req_wdata == `ACTION_TRIGGER);
    end
  endgenerate

  // pulses come from their own flops so the outputs stay registered
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      history_alarm_clear_pulse <= 1'b0;
      active_alarm_clear_pulse  <= 1'b0;
      encoder_alarm_clear_pulse <= 1'b0;
      encoder_turns_clear_pulse <= 1'b0;
      factory_default_pulse     <= 1'b0;
      drive_reset_pulse         <= 1'b0;
    end else if (ce) begin
      history_alarm_clear_pulse <= fire[0];
      active_alarm_clear_pulse  <= fire[1];
      encoder_alarm_clear_pulse <= fire[2];
      encoder_turns_clear_pulse <= fire[3];
      factory_default_pulse     <= fire[4];
      drive_reset_pulse         <= fire[5];
    end
  end

endmodule

// File: sim/servo_monitor_command_regs_props.sv
// concurrent checks on the register bank ports
`timescale 1ns/1ns
module servo_monitor_regs_props (
  // clock and reset
  input wire        clk,
  input wire        rst_n,
  input wire        ce,
  // requests and answers
  input wire        req_valid,
  input wire        req_write,
  input wire [15:0] req_addr,
  input wire [15:0] req_wdata,
  input wire        rsp_valid,
  input wire [15:0] rsp_rdata,
  input wire        rsp_error,
  input wire [7:0]  rsp_code,
  // watched state
  input wire [31:0] command_pulse_count,
  input wire [31:0] gear_numerator,
  input wire        jog_servo_enable,
  input wire        jog_forward,
  input wire        active_alarm_clear_pulse,
  input wire        encoder_turns_clear_pulse
);
  wire take = ce && req_valid;
  wire wr   = take && req_write;
  wire one  = req_wdata == 16'h0001;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // answer timing and codes
  a_answer_next: assert property (take |=> rsp_valid)
    else $error("no answer one cycle after a request");
  // a frozen cycle keeps the last answer, so only enabled idle edges count
  a_no_stray: assert property (ce && !req_valid |=> !rsp_valid)
    else $error("answer without a request");
  a_bad_code: assert property (rsp_valid && rsp_error
    |-> rsp_code == 8'h02)
    else $error("error answer without code 02");
  a_good_code: assert property (rsp_valid && !rsp_error
    |-> rsp_code == 8'h00)
    else $error("good answer with nonzero code");
  a_count_read: assert property (
    take && !req_write && req_addr == 16'h0434
    |=> !rsp_error && rsp_rdata == $past(command_pulse_count[15:0]))
    else $error("pulse count low word wrong");
  // ==========================================================
  // actions and settings
  a_clear_once: assert property (
    wr && req_addr == 16'h0521 && one
    |=> (active_alarm_clear_pulse and
         (ce && !(wr && req_addr == 16'h0521 && one)
          |=> !active_alarm_clear_pulse)))
    else $error("alarm clear pulse missing or long");
  a_clear_cause: assert property (active_alarm_clear_pulse
    |-> $past(!ce || (wr && req_addr == 16'h0521 && one)))
    else $error("alarm clear pulse without a write of one");
  a_zero_ignored: assert property (
    wr && req_addr == 16'h0523 && !one |=> !encoder_turns_clear_pulse)
    else $error("turn clear on a write other than one");
  a_jog_follow: assert property (wr && req_addr == 16'h0528
    |=> jog_servo_enable == $past(req_wdata[15])
        && jog_forward == $past(req_wdata[1]))
    else $error("jog bits do not follow the write");
  a_gear_staged: assert property (wr && req_addr == 16'h0460
    |=> $stable(gear_numerator))
    else $error("gear low word write changed the ratio");
endmodule

bind servo_monitor_command_regs servo_monitor_regs_props props (
  .clk(clk), .rst_n(rst_n), .ce(ce), .req_valid(req_valid),
  .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
  .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_error(rsp_error),
  .rsp_code(rsp_code), .command_pulse_count(command_pulse_count),
  .gear_numerator(gear_numerator), .jog_servo_enable(jog_servo_enable),
  .jog_forward(jog_forward),
  .active_alarm_clear_pulse(active_alarm_clear_pulse),
  .encoder_turns_clear_pulse(encoder_turns_clear_pulse));

// File: sim/servo_monitor_host.sv
// link master model issuing word requests to the register bank
`timescale 1ns/1ns
module servo_monitor_host (
  // clock
  input  wire        clk,
  // request
  output reg         req_valid,
  output reg         req_write,
  output reg  [15:0] req_addr,
  output reg  [15:0] req_wdata,
  // answer
  input  wire        rsp_valid,
  input  wire [15:0] rsp_rdata,
  input  wire        rsp_error
);
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 16'h0000;
    req_wdata = 16'h0000;
  end
  // idle gap first, so slow as well as prompt hosts are covered
  task xfer(input bit w, input [15:0] a, input [15:0] d, input int gap,
            output [15:0] rd, output logic err, output bit ok);
    int n;
    begin
      repeat (gap) @(posedge clk);
      @(posedge clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_wdata <= d;
      @(posedge clk);
      // released lines carry the inverse so stale values never match
      req_valid <= 1'b0;
      req_addr <= ~a;
      req_wdata <= ~d;
      ok = 1'b0;
      for (n = 0; n < 4 && !ok; n++) begin
        @(posedge clk);
        ok = rsp_valid === 1'b1;
      end
      rd = rsp_rdata;
      err = rsp_error;
    end
  endtask
endmodule

// File: sim/servo_monitor_command_regs_tb_top.sv
// self-checking bench of the register bank against a reference model
`timescale 1ns/1ns
module servo_monitor_command_regs_tb_top;
  reg         clk, rst_n, ce, err;
  reg  [31:0] mon [0:11];
  wire        req_valid, req_write, rsp_valid, rsp_error;
  wire [15:0] req_addr, req_wdata, rsp_rdata, io, inv;
  wire [31:0] gn, gd;
  wire [7:0]  code;
  wire [5:0]  pul, jog;
  reg  [15:0] m_io, m_inv, m_js, m_jp, stg, snap, sb, e_rd, rd, a, d;
  reg  [31:0] m_gn, m_gd, v, r, seed = 32'd80162;
  reg  [5:0]  e_pul;
  bit         has, wide, e_err, ok, w;
  int         miscompares, total_checks, i;
  bit  [15:0] tbl[$] = '{16'h0434, 16'h0435, 16'h0436, 16'h0437, 16'h0438,
    16'h0439, 16'h043a, 16'h043b, 16'h043c, 16'h043d, 16'h043e, 16'h043f,
    16'h0440, 16'h0441, 16'h0442, 16'h044a, 16'h044b, 16'h0451, 16'h0452,
    16'h0453, 16'h0457, 16'h045e, 16'h045f, 16'h0460, 16'h0461, 16'h0462,
    16'h0463, 16'h0520, 16'h0521, 16'h0522, 16'h0523, 16'h0524, 16'h0528,
    16'h0529, 16'h0540, 16'h0541, 16'h05f0, 16'h05f1, 16'h05f2, 16'h05f3,
    16'h05f4};
  servo_monitor_command_regs dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_error(rsp_error),
    .rsp_code(code), .command_pulse_count(mon[0]),
    .feedback_pulse_count(mon[1]), .following_error_count(mon[2]),
    .cumulative_load(mon[3]), .inertia_ratio(mon[4]),
    .encoder_angle(mon[5]), .encoder_turn_count(mon[6]),
    .active_alarm(mon[8][15:0]), .operating_state(mon[9][15:0]),
    .running_group_number(mon[10][15:0]),
    .running_group_index(mon[11][15:0]), .actual_position(mon[7]),
    .link_io_signals(io), .link_output_invert(inv), .gear_numerator(gn),
    .gear_denominator(gd), .jog_servo_enable(jog[5]),
    .jog_forward(jog[4]), .jog_reverse(jog[3]), .point_mode_enable(jog[2]),
    .point_forward(jog[1]), .point_reverse(jog[0]),
    .history_alarm_clear_pulse(pul[0]), .active_alarm_clear_pulse(pul[1]),
    .encoder_alarm_clear_pulse(pul[2]), .encoder_turns_clear_pulse(pul[3]),
    .factory_default_pulse(pul[4]), .drive_reset_pulse(pul[5]));
  servo_monitor_host host (.clk(clk), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_error(rsp_error));
  // ==========================================================
  // helpers and reference model
  function automatic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task defaults;
    {m_io, m_inv, m_js, m_jp} = 64'h0;
    m_gn = 32'h1;
    m_gd = 32'h1;
  endtask
  task model(input bit w, input [15:0] a, input [15:0] d);
    wide = (a >= 16'h0434 && a <= 16'h0441) || (a >= 16'h0460
      && a <= 16'h0463) || a == 16'h05f2 || a == 16'h05f3;
    v = a >= 16'h05f2 ? mon[7] : a >= 16'h0460 ? (a[1] ? m_gd : m_gn)
      : mon[(a - 16'h0434) >> 1];
    // snapshot only serves the odd partner of the word that took it
    e_rd = a[0] ? (has && sb == {a[15:1], 1'b0} ? snap : v[31:16])
      : v[15:0];
    if (wide && !w) has = !a[0];
    if (wide && !w && !a[0]) {sb, snap} = {a, v[31:16]};
    e_err = 1'b0;
    e_pul = 6'h00;
    case (a)
      16'h044a: e_rd = mon[8][15:0];
      16'h0451: e_rd = m_io;
      16'h0452: e_rd = m_inv;
      16'h0457: e_rd = mon[9][15:0];
      16'h045e, 16'h045f: e_rd = 16'h0001;
      16'h0528: e_rd = m_js;
      16'h0529: e_rd = m_jp;
      16'h05f0: e_rd = mon[10][15:0];
      16'h05f1: e_rd = mon[11][15:0];
      16'h0520, 16'h0521, 16'h0522, 16'h0523, 16'h0540, 16'h0541: e_rd = 0;
      default: e_err = !wide;
    endcase
    if (w || e_err) e_rd = 16'h0000;
    if (w && d == 16'h0001 && a[15:2] == 14'h0148) e_pul[a[1:0]] = 1'b1;
    if (w && d == 16'h0001 && a[15:1] == 15'h02a0) e_pul[4 + a[0]] = 1'b1;
    if (w)
      case (a)
        16'h0451: m_io = d;
        16'h0452: m_inv = d;
        16'h0528: m_js = d;
        16'h0529: m_jp = d;
        16'h0460, 16'h0462: stg = d;
        16'h0461: m_gn = {d, stg};
        16'h0463: m_gd = {d, stg};
        16'h0540: if (d == 16'h0001) defaults();
      endcase
  endtask
  task acc(input bit w, input [15:0] a, input [15:0] d);
    int j;
    for (j = 0; j < 12; j++) mon[j] <= rnd();
    host.xfer(w, a, d, int'(rnd() % 3), rd, err, ok);
    model(w, a, d);
    check(ok, 32'h1);
    check(err, e_err);
    check(rd, e_rd);
    check(pul, e_pul);
    check({io, inv}, {m_io, m_inv});
    check(gn, m_gn);
    check(gd, m_gd);
    check(code, e_err ? 8'h02 : 8'h00);
    check(jog, {m_js[15], m_js[1:0], m_jp[15], m_jp[1:0]});
  endtask
  task test_done;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========================================================
  // clock, watchdog and sequence
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #400000;
    miscompares++;
    test_done();
  end
  initial begin
    rst_n = 1'b0;
    for (i = 0; i < 12; i++) mon[i] = 32'h0;
    defaults();
    has = 1'b0;
    stg = 16'h0000;
    ce = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // table order keeps each low word read right before its high word
    foreach (tbl[k]) acc(1'b0, tbl[k], 16'h0000);
    foreach (tbl[k]) begin
      acc(1'b1, tbl[k], 16'h0001);
      acc(1'b1, tbl[k], 16'h0000);
    end
    acc(1'b1, 16'h0528, 16'h8003);
    acc(1'b1, 16'h0529, 16'h8002);
    // a request while frozen is never taken
    ce <= 1'b0;
    host.xfer(1'b1, 16'h0521, 16'h0001, 0, rd, err, ok);
    check(ok, 32'h0);
    check(pul, 6'h00);
    ce <= 1'b1;
    for (i = 0; i < 150; i++) begin
      r = rnd();
      a = tbl[r % tbl.size()];
      w = r[20];
      d = r[21] ? 16'h0001 : r[31:16];
      acc(w, a, d);
      if (!a[0]) acc(w, a + 16'h0001, r[15:0]);
    end
    test_done();
  end
endmodule
